// >>> logic/emb_defines.svh
// Constants for the embedded memory block
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define EMB_TOTAL_BITS 2048
`define EMB_WORDS 256
`define EMB_WIDTH 8
`define EMB_WORD_AW 8
`define EMB_ADDR_W 11
`define EMB_CNT_W 12

// ----------------------------------------------------------------
// Organisation codes and lane layouts
// ----------------------------------------------------------------
`define EMB_SHAPE_256X8 2'b00
`define EMB_SHAPE_512X4 2'b01
`define EMB_SHAPE_1KX2 2'b10
`define EMB_SHAPE_2KX1 2'b11
`define EMB_BASE_X8 8'hff
`define EMB_BASE_X4 8'h0f
`define EMB_BASE_X2 8'h03
`define EMB_BASE_X1 8'h01

// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define EMB_MODE_RAM 2'b00
`define EMB_MODE_ROM 2'b01
`define EMB_MODE_DPRAM 2'b10
`define EMB_MODE_FIFO 2'b11

// ----------------------------------------------------------------
// Clock source codes and reset values
// ----------------------------------------------------------------
`define EMB_CLK_GLOBAL 2'b00
`define EMB_CLK_PIN 2'b01
`define EMB_CLK_LOCAL 2'b10
`define EMB_NCLK_SRC 3
`define EMB_RST_BYTE 8'h00
`define EMB_RST_ADDR 11'h000
`define EMB_RST_CNT 12'h000
`define EMB_RST_SYNC 3'h0
`define EMB_PTR_ONE 11'h001
`define EMB_CNT_ONE 12'h001

`endif

// >>> logic/emb_pkg.sv
// Types shared by the embedded memory block files
`include "emb_defines.svh"

package emb_pkg;

   typedef enum logic [1:0] {
      EMB_RAM = `EMB_MODE_RAM,
      EMB_ROM = `EMB_MODE_ROM,
      EMB_DPRAM = `EMB_MODE_DPRAM,
      EMB_FIFO = `EMB_MODE_FIFO
   } emb_mode_e;

   typedef enum logic [1:0] {
      EMB_X8 = `EMB_SHAPE_256X8,
      EMB_X4 = `EMB_SHAPE_512X4,
      EMB_X2 = `EMB_SHAPE_1KX2,
      EMB_X1 = `EMB_SHAPE_2KX1
   } emb_shape_e;

   typedef enum logic [1:0] {
      EMB_SRC_GLOBAL = `EMB_CLK_GLOBAL,
      EMB_SRC_PIN = `EMB_CLK_PIN,
      EMB_SRC_LOCAL = `EMB_CLK_LOCAL
   } emb_clk_src_e;

endpackage : emb_pkg

// >>> logic/emb_mem.sv
// Storage array with bit-masked write and registered read
`timescale 1ns/10ps
`include "emb_defines.svh"

module emb_mem #(
   parameter int WORDS = `EMB_WORDS,
   parameter int WIDTH = `EMB_WIDTH,
   parameter int AW = `EMB_WORD_AW
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wmask,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);

   logic [WIDTH-1:0] mem_array [WORDS];
   logic [WIDTH-1:0] rdata_next;

   always_comb begin
      rdata_next = mem_array[i_raddr];
   end

   // Read samples the array before this edge's write: old data wins
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= rdata_next;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem_array[i_waddr] <= (mem_array[i_waddr] & ~i_wmask) |
                               (i_wdata & i_wmask);
      end
   end

endmodule : emb_mem

// >>> logic/emb_block.sv
// Configurable 2048-bit embedded memory block top level
//
// Summary of operation
// - 2048 bits; RAM, ROM, dual-port or FIFO
// - Shapes 256x8, 512x4, 1024x2, 2048x1
// - Write strobe made inside from clock
// - ROM preloaded, then pure lookup table
// - Separate input and output side clocks
// - Bypassable data, output, address registers
// - Write request from global or local
// - Clock from global, pin or local
// - Same-shape blocks share address for width
// - Depth cascade by block select, no latency
`timescale 1ns/10ps
`include "emb_defines.svh"

module emb_block (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire emb_pkg::emb_mode_e i_cfg_mode,
   input wire emb_pkg::emb_shape_e i_cfg_shape,
   input wire logic i_cfg_reg_din,
   input wire logic i_cfg_reg_dout,
   input wire logic i_cfg_reg_addr,
   input wire logic i_cfg_we_global,
   input wire emb_pkg::emb_clk_src_e i_cfg_in_clk,
   input wire emb_pkg::emb_clk_src_e i_cfg_out_clk,
   input wire logic i_glb_clk,
   input wire logic i_pin_clk,
   input wire logic i_loc_clk,
   input wire logic i_glb_we,
   input wire logic i_loc_we,
   input wire logic i_blk_sel,
   input wire logic [`EMB_ADDR_W-1:0] i_addr,
   input wire logic [`EMB_WIDTH-1:0] i_wdata,
   input wire logic [`EMB_ADDR_W-1:0] i_raddr,
   input wire logic i_load_en,
   input wire logic [`EMB_ADDR_W-1:0] i_load_addr,
   input wire logic [`EMB_WIDTH-1:0] i_load_data,
   input wire logic i_fifo_push,
   input wire logic i_fifo_pop,
   output logic [`EMB_WIDTH-1:0] o_rdata,
   output logic o_wr_done,
   output logic o_fifo_full,
   output logic o_fifo_empty
);
   import emb_pkg::*;

   // ----------------------------------------------------------------
   // Lane helpers
   // ----------------------------------------------------------------
   function automatic logic [`EMB_WORD_AW-1:0] emb_word_idx(
      input logic [1:0] shape, input logic [`EMB_ADDR_W-1:0] addr);
      logic [`EMB_ADDR_W-1:0] s;
      s = addr >> shape;
      return s[`EMB_WORD_AW-1:0];
   endfunction : emb_word_idx

   function automatic logic [2:0] emb_lane_pos(
      input logic [1:0] shape, input logic [`EMB_ADDR_W-1:0] addr);
      logic [2:0] p;
      p = 3'h0;
      unique case (shape)
         `EMB_SHAPE_256X8: p = 3'h0;
         `EMB_SHAPE_512X4: p = {addr[0], 2'b00};
         `EMB_SHAPE_1KX2: p = {addr[1:0], 1'b0};
         `EMB_SHAPE_2KX1: p = addr[2:0];
      endcase
      return p;
   endfunction : emb_lane_pos

   function automatic logic [`EMB_WIDTH-1:0] emb_lane_base(
      input logic [1:0] shape);
      logic [`EMB_WIDTH-1:0] b;
      b = `EMB_BASE_X8;
      unique case (shape)
         `EMB_SHAPE_256X8: b = `EMB_BASE_X8;
         `EMB_SHAPE_512X4: b = `EMB_BASE_X4;
         `EMB_SHAPE_1KX2: b = `EMB_BASE_X2;
         `EMB_SHAPE_2KX1: b = `EMB_BASE_X1;
      endcase
      return b;
   endfunction : emb_lane_base

   function automatic logic [`EMB_CNT_W-1:0] emb_depth(
      input logic [1:0] shape);
      logic [`EMB_CNT_W-1:0] d;
      d = `EMB_CNT_W'(`EMB_WORDS) << shape;
      return d;
   endfunction : emb_depth

   // ----------------------------------------------------------------
   // Clock source synchronisers and edge ticks
   // ----------------------------------------------------------------
   logic [`EMB_NCLK_SRC-1:0] sync1_reg, sync2_reg, prev_reg;
   logic [`EMB_NCLK_SRC-1:0] sync1_next, sync2_next, prev_next;
   logic [`EMB_NCLK_SRC-1:0] rise;
   logic in_tick, out_tick;

   always_comb begin
      sync1_next = {i_loc_clk, i_pin_clk, i_glb_clk};
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
      rise = sync2_reg & ~prev_reg;
      in_tick = rise[i_cfg_in_clk];
      out_tick = rise[i_cfg_out_clk];
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_reg <= `EMB_RST_SYNC;
         sync2_reg <= `EMB_RST_SYNC;
         prev_reg <= `EMB_RST_SYNC;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
      end
   end

   // ----------------------------------------------------------------
   // Input side: capture registers, write strobe, FIFO pointers
   // ----------------------------------------------------------------
   logic [`EMB_ADDR_W-1:0] addr_reg, addr_next;
   logic we_reg, we_next;
   logic [`EMB_WIDTH-1:0] din_reg, din_next;
   logic [`EMB_ADDR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [`EMB_CNT_W-1:0] cnt_reg, cnt_next;
   logic done_reg, done_next;
   logic full_reg, full_next, empty_reg, empty_next;
   logic [`EMB_ADDR_W-1:0] addr_eff, wr_addr, rd_addr;
   logic [`EMB_WIDTH-1:0] din_eff, wr_src, wr_data, wr_mask;
   logic we_src, we_eff, wr_stb, push_ok, pop_ok;
   logic [2:0] wr_pos;

   always_comb begin
      we_src = i_cfg_we_global ? i_glb_we : i_loc_we;
      addr_eff = i_cfg_reg_addr ? addr_reg : i_addr;
      we_eff = i_cfg_reg_addr ? we_reg : we_src;
      din_eff = i_cfg_reg_din ? din_reg : i_wdata;
      addr_next = in_tick ? i_addr : addr_reg;
      we_next = in_tick ? we_src : we_reg;
      din_next = in_tick ? i_wdata : din_reg;
      push_ok = in_tick & i_fifo_push & i_blk_sel & ~full_reg;
      pop_ok = in_tick & i_fifo_pop & i_blk_sel & ~empty_reg;
      wr_stb = 1'b0;
      wr_addr = addr_eff;
      wr_src = din_eff;
      rd_addr = addr_eff;
      wptr_next = wptr_reg;
      rptr_next = rptr_reg;
      cnt_next = cnt_reg;
      unique case (i_cfg_mode)
         EMB_RAM: begin
            wr_stb = in_tick & we_eff & i_blk_sel;
         end
         EMB_ROM: begin
            wr_stb = i_load_en;
            wr_addr = i_load_addr;
            wr_src = i_load_data;
         end
         EMB_DPRAM: begin
            wr_stb = in_tick & we_eff & i_blk_sel;
            rd_addr = i_raddr;
         end
         EMB_FIFO: begin
            wr_stb = push_ok;
            wr_addr = wptr_reg;
            rd_addr = rptr_reg;
            if (push_ok) begin
               wptr_next = wptr_reg + `EMB_PTR_ONE;
            end
            if (pop_ok) begin
               rptr_next = rptr_reg + `EMB_PTR_ONE;
            end
            if (push_ok && !pop_ok) begin
               cnt_next = cnt_reg + `EMB_CNT_ONE;
            end else if (pop_ok && !push_ok) begin
               cnt_next = cnt_reg - `EMB_CNT_ONE;
            end
            if (wptr_next == `EMB_ADDR_W'(emb_depth(i_cfg_shape))) begin
               wptr_next = `EMB_RST_ADDR;
            end
            if (rptr_next == `EMB_ADDR_W'(emb_depth(i_cfg_shape))) begin
               rptr_next = `EMB_RST_ADDR;
            end
         end
      endcase
      wr_pos = emb_lane_pos(i_cfg_shape, wr_addr);
      wr_mask = emb_lane_base(i_cfg_shape) << wr_pos;
      wr_data = (wr_src & emb_lane_base(i_cfg_shape)) << wr_pos;
      done_next = wr_stb;
      full_next = (i_cfg_mode == EMB_FIFO) &&
                  (cnt_next == emb_depth(i_cfg_shape));
      empty_next = (i_cfg_mode != EMB_FIFO) || (cnt_next == `EMB_RST_CNT);
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         addr_reg <= `EMB_RST_ADDR;
         we_reg <= 1'b0;
         din_reg <= `EMB_RST_BYTE;
         wptr_reg <= `EMB_RST_ADDR;
         rptr_reg <= `EMB_RST_ADDR;
         cnt_reg <= `EMB_RST_CNT;
         done_reg <= 1'b0;
         full_reg <= 1'b0;
         empty_reg <= 1'b1;
      end else begin
         addr_reg <= addr_next;
         we_reg <= we_next;
         din_reg <= din_next;
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg <= cnt_next;
         done_reg <= done_next;
         full_reg <= full_next;
         empty_reg <= empty_next;
      end
   end

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [`EMB_WIDTH-1:0] mem_rdata;
   logic [2:0] rd_pos_reg, rd_pos_next;

   emb_mem #(
      .WORDS(`EMB_WORDS),
      .WIDTH(`EMB_WIDTH),
      .AW(`EMB_WORD_AW)
   ) u_mem (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_we(wr_stb),
      .i_waddr(emb_word_idx(i_cfg_shape, wr_addr)),
      .i_wmask(wr_mask),
      .i_wdata(wr_data),
      .i_raddr(emb_word_idx(i_cfg_shape, rd_addr)),
      .o_rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // Output side
   // ----------------------------------------------------------------
   logic [`EMB_WIDTH-1:0] rd_lane;
   logic [`EMB_WIDTH-1:0] rdata_reg, rdata_next;

   always_comb begin
      rd_pos_next = emb_lane_pos(i_cfg_shape, rd_addr);
      rd_lane = (mem_rdata >> rd_pos_reg) & emb_lane_base(i_cfg_shape);
      rdata_next = rdata_reg;
      if (!i_cfg_reg_dout || out_tick) begin
         rdata_next = rd_lane;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_pos_reg <= 3'h0;
         rdata_reg <= `EMB_RST_BYTE;
      end else begin
         rd_pos_reg <= rd_pos_next;
         rdata_reg <= rdata_next;
      end
   end

   always_comb begin
      o_rdata = rdata_reg;
      o_wr_done = done_reg;
      o_fifo_full = full_reg;
      o_fifo_empty = empty_reg;
   end

endmodule : emb_block

// >>> bench/emb_user_src.sv
// User logic model: clock source pulses on request
`timescale 1ns/10ps
module emb_user_src (
   input wire logic i_mclk,
   input wire logic [2:0] i_fire,
   output logic [2:0] o_src
);
   logic [2:0][3:0] cnt_reg = '0;
   logic [2:0][3:0] cnt_next;
   // One eight-cycle period per request, low between
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         cnt_next[k] = cnt_reg[k] - {3'h0, cnt_reg[k] != 4'h0};
         if (i_fire[k] && cnt_reg[k] == 4'h0) begin
            cnt_next[k] = 4'h8;
         end
         o_src[k] = cnt_reg[k] > 4'h4;
      end
   end
   always_ff @(posedge i_mclk) begin
      cnt_reg <= cnt_next;
   end
endmodule : emb_user_src

// >>> bench/emb_block_properties.sv
// Port assertions for the embedded memory block
`timescale 1ns/10ps
module emb_block_properties (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire emb_pkg::emb_mode_e i_cfg_mode,
   input wire emb_pkg::emb_shape_e i_cfg_shape,
   input wire logic i_cfg_reg_dout,
   input wire logic i_cfg_reg_addr,
   input wire logic i_cfg_we_global,
   input wire emb_pkg::emb_clk_src_e i_cfg_in_clk,
   input wire logic i_glb_clk,
   input wire logic i_pin_clk,
   input wire logic i_loc_clk,
   input wire logic i_glb_we,
   input wire logic i_loc_we,
   input wire logic i_blk_sel,
   input wire logic [7:0] o_rdata,
   input wire logic o_wr_done,
   input wire logic o_fifo_full,
   input wire logic o_fifo_empty
);
   import emb_pkg::*;
   logic [2:0] srcs;
   logic in_hi, we_sel, ram_wr;
   logic [3:0] ia_reg, ia_next;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   assign srcs = {i_loc_clk, i_pin_clk, i_glb_clk};
   assign in_hi = srcs[i_cfg_in_clk];
   assign we_sel = i_cfg_we_global ? i_glb_we : i_loc_we;
   assign ram_wr = o_wr_done && i_cfg_mode == EMB_RAM && !i_cfg_reg_addr;
   // Cycles since the input clock source was last high
   always_comb begin
      ia_next = in_hi ? 4'h0 : ia_reg + {3'h0, ia_reg != 4'hf};
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ia_reg <= 4'hf;
      end else begin
         ia_reg <= ia_next;
      end
   end
   sequence s_pulse;
      o_wr_done ##1 !o_wr_done;
   endsequence
   chk_done_pulse: assert property ($rose(o_wr_done) |-> s_pulse)
      else $error("write done too long");
   chk_done_src: assert property (o_wr_done &&
      i_cfg_mode inside {EMB_RAM, EMB_DPRAM} |-> ia_reg <= 4'h6)
      else $error("write without source edge");
   chk_we_src: assert property (ram_wr |-> $past(we_sel))
      else $error("write without selected request");
   chk_blk_gate: assert property (ram_wr |-> $past(i_blk_sel))
      else $error("write while deselected");
   chk_idle_empty: assert property (
      (i_cfg_mode != EMB_FIFO)[*2] |-> o_fifo_empty)
      else $error("empty low outside queue use");
   chk_flag_excl: assert property (!(o_fifo_full && o_fifo_empty))
      else $error("full and empty together");
   chk_x1_zero: assert property (
      (i_cfg_shape == EMB_X1 && !i_cfg_reg_dout)[*3] |-> o_rdata[7:1] == 7'h00)
      else $error("upper bits set in x1");
   chk_x4_zero: assert property (
      (i_cfg_shape == EMB_X4 && !i_cfg_reg_dout)[*3] |-> o_rdata[7:4] == 4'h0)
      else $error("upper bits set in x4");
endmodule : emb_block_properties

bind emb_block emb_block_properties chk_u (.i_mclk, .i_nrst, .i_cfg_mode,
   .i_cfg_shape, .i_cfg_reg_dout, .i_cfg_reg_addr, .i_cfg_we_global,
   .i_cfg_in_clk, .i_glb_clk, .i_pin_clk, .i_loc_clk, .i_glb_we,
   .i_loc_we, .i_blk_sel, .o_rdata, .o_wr_done, .o_fifo_full,
   .o_fifo_empty);

// >>> bench/testbench.sv
// Self-checking testbench for the embedded memory block
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
$display("unexpected %0t got %h want %h", $time, a, b); end end
module testbench;
   import emb_pkg::*;
   logic i_mclk = 1'b0, i_nrst = 1'b0, ok_we = 1'b1, blk = 1'b1;
   logic wglb = 1'b1, gwe = 1'b0, lwe = 1'b0, ld = 1'b0;
   logic push = 1'b0, pop = 1'b0;
   emb_mode_e mode = EMB_RAM;
   emb_shape_e shape = EMB_X8;
   emb_clk_src_e isrc = EMB_SRC_GLOBAL;
   logic [10:0] addr = 11'h000, raddr = 11'h000;
   logic [7:0] wdata = 8'h00, snap, rdata;
   logic [2:0] fire = 3'h0, src;
   logic done, full, empty;
   int n_errors = 0, n_compared = 0;
   always #12.5 i_mclk = ~i_mclk;
   emb_block dut_u (.i_mclk, .i_nrst, .i_cfg_mode(mode),
      .i_cfg_shape(shape), .i_cfg_reg_din(1'b0), .i_cfg_reg_dout(1'b0),
      .i_cfg_reg_addr(1'b0), .i_cfg_we_global(wglb), .i_cfg_in_clk(isrc),
      .i_cfg_out_clk(isrc), .i_glb_clk(src[0]), .i_pin_clk(src[1]),
      .i_loc_clk(src[2]), .i_glb_we(gwe), .i_loc_we(lwe),
      .i_blk_sel(blk), .i_addr(addr), .i_wdata(wdata), .i_raddr(raddr),
      .i_load_en(ld), .i_load_addr(addr), .i_load_data(wdata),
      .i_fifo_push(push), .i_fifo_pop(pop), .o_rdata(rdata),
      .o_wr_done(done), .o_fifo_full(full), .o_fifo_empty(empty));
   emb_user_src src_u (.i_mclk, .i_fire(fire), .o_src(src));
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc
   task automatic wr(input logic [10:0] a, input logic [7:0] d, input bit ok);
      bit seen;
      seen = 1'b0;
      @(posedge i_mclk);
      addr <= a;
      wdata <= d;
      gwe <= wglb ~^ ok_we;
      lwe <= wglb ^ ok_we;
      fire[isrc] <= 1'b1;
      cyc(1);
      fire <= 3'h0;
      for (int i = 0; i < 16 && !seen; i++) begin
         cyc(1);
         #1 seen = done;
      end
      `CHK(seen, ok)
      if (ok && !seen) final_report();
      gwe <= 1'b0;
      lwe <= 1'b0;
      cyc(1);
      #1 `CHK(done, 1'b0)
      // Read data here came from the array on the write edge
      snap = rdata;
      cyc(4);
   endtask : wr
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      addr <= a;
      raddr <= a;
      cyc(3);
      #1 `CHK(rdata, e)
   endtask : rd
   initial begin
      cyc(12);
      #1 `CHK({rdata, done, full, empty}, 11'h001)
      i_nrst <= 1'b1;
      wr(11'h005, 8'ha5, 1'b1);
      wr(11'h0ff, 8'h3c, 1'b1);
      rd(11'h005, 8'ha5);
      shape <= EMB_X1;
      wr(11'h7ff, 8'h01, 1'b1);
      rd(11'h7fd, 8'h01);
      rd(11'h7fe, 8'h00);
      shape <= EMB_X2;
      rd(11'h3fe, 8'h03);
      shape <= EMB_X4;
      rd(11'h1ff, 8'h0b);
      shape <= EMB_X8;
      rd(11'h0ff, 8'hbc);
      $display("shapes done");
      for (int k = 0; k < 3; k++) begin
         isrc <= emb_clk_src_e'(k);
         wglb <= k[0];
         wr(11'(k + 64), 8'(k + 16), 1'b1);
         rd(11'(k + 64), 8'(k + 16));
      end
      ok_we <= 1'b0;
      wr(11'h040, 8'hee, 1'b0);
      ok_we <= 1'b1;
      blk <= 1'b0;
      wr(11'h005, 8'h00, 1'b0);
      blk <= 1'b1;
      rd(11'h040, 8'h10);
      rd(11'h005, 8'ha5);
      $display("sources done");
      mode <= EMB_ROM;
      @(posedge i_mclk);
      addr <= 11'h020;
      wdata <= 8'h5a;
      ld <= 1'b1;
      cyc(1);
      ld <= 1'b0;
      rd(11'h020, 8'h5a);
      wr(11'h020, 8'h00, 1'b0);
      rd(11'h020, 8'h5a);
      $display("lookup done");
      mode <= EMB_DPRAM;
      wr(11'h030, 8'h11, 1'b1);
      rd(11'h030, 8'h11);
      wr(11'h030, 8'h22, 1'b1);
      `CHK(snap, 8'h11)
      rd(11'h030, 8'h22);
      $display("dual port done");
      mode <= EMB_FIFO;
      push <= 1'b1;
      wr(11'h000, 8'h77, 1'b1);
      `CHK({empty, full, rdata}, 10'h077)
      push <= 1'b0;
      pop <= 1'b1;
      wr(11'h000, 8'h00, 1'b0);
      pop <= 1'b0;
      `CHK({empty, full}, 2'b10)
      $display("queue done");
      final_report();
   end
endmodule : testbench
